// ---- rtl/qdac_pkg.sv ----
// Constants shared by the quad converter serial command front end.
// Assumes a 24-bit frame shifted in most significant bit first.
package qdac_pkg;
    localparam int WORD_W       = 24;
    localparam int DATA_W       = 12;
    localparam int CHAN_N       = 4;
    localparam int CNT_W        = 5;
    localparam int ENTRY_W      = DATA_W + 1;
    // Bit positions inside the command word.
    localparam int ADDR_HI_BIT  = 23;
    localparam int ADDR_LO_BIT  = 22;
    localparam int LOAD_HI_BIT  = 21;
    localparam int LOAD_LO_BIT  = 20;
    localparam int ZERO_BIT     = 19;
    localparam int SEL_HI_BIT   = 18;
    localparam int SEL_LO_BIT   = 17;
    localparam int PD_BIT       = 16;
    localparam int DATA_HI_BIT  = 15;
    localparam int DATA_LO_BIT  = 4;
    // Frame length and reset values.
    localparam logic [CNT_W-1:0]   LAST_BIT_CNT = 5'h17;
    localparam logic [CNT_W-1:0]   FULL_CNT     = 5'h18;
    localparam logic [ENTRY_W-1:0] ENTRY_RESET  = 13'h0000;
    localparam logic [WORD_W-1:0]  WORD_RESET   = 24'h000000;
    // Load control encodings.
    localparam logic [1:0] LOAD_STORE  = 2'h0;
    localparam logic [1:0] LOAD_SINGLE = 2'h1;
    localparam logic [1:0] LOAD_SIMUL  = 2'h2;
    localparam logic [1:0] LOAD_BCAST  = 2'h3;
endpackage

// ---- rtl/qdac_link_rx.sv ----
// Serial receiver running on the falling edge of the link clock.
// Assumes the link clock only moves while the frame strobe is low.
`timescale 1ns/1ps
module qdac_link_rx (
    input  wire logic                        rst_in,
    input  wire logic                        sclk_in,
    input  wire logic                        frame_n_in,
    input  wire logic                        sdata_in,
    output logic [qdac_pkg::WORD_W-1:0]      word_out,
    output logic                             word_tgl_out
);
    typedef struct packed {
        logic [qdac_pkg::WORD_W-2:0] shift;
        logic [qdac_pkg::CNT_W-1:0]  count;
    } qdac_rx_t;

    typedef struct packed {
        logic [qdac_pkg::WORD_W-1:0] word;
        logic                        tgl;
    } qdac_hold_t;

    qdac_rx_t   rx_q, rx_d;
    qdac_hold_t hold_q, hold_d;
    logic       frame_clr;

    // A high frame strobe wipes a partial word and the bit count.
    assign frame_clr = rst_in | frame_n_in; // [RULE6] [RULE21]

    always_comb begin
        rx_d   = rx_q;
        hold_d = hold_q;
        if (rx_q.count != qdac_pkg::FULL_CNT) begin // [RULE4]
            rx_d.shift = {rx_q.shift[qdac_pkg::WORD_W-3:0], sdata_in}; // [RULE2]
            rx_d.count = rx_q.count + 5'h01; // [RULE21]
        end
        if (rx_q.count == qdac_pkg::LAST_BIT_CNT) begin
            hold_d.word = {rx_q.shift, sdata_in}; // [RULE1] [RULE4]
            hold_d.tgl  = ~hold_q.tgl;
        end
    end

    // The frame strobe clears only the receive state, never the held word.
    always_ff @(negedge sclk_in or posedge frame_clr) begin // [RULE3]
        if (frame_clr) begin
            rx_q <= '0; // [RULE7]
        end else begin
            rx_q <= rx_d;
        end
    end

    always_ff @(negedge sclk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_q <= '0;
        end else begin
            hold_q <= hold_d;
        end
    end

    assign word_out     = hold_q.word;
    assign word_tgl_out = hold_q.tgl;

    chk_count_bound: assert property ( // [RULE4]
        @(negedge sclk_in) disable iff (frame_clr)
        rx_q.count <= qdac_pkg::FULL_CNT)
        else $error("Bit count ran past the frame length.");

    chk_word_frozen: assert property ( // [RULE4]
        @(negedge sclk_in) disable iff (frame_clr)
        rx_q.count == qdac_pkg::FULL_CNT |=> $stable(hold_q))
        else $error("Held word changed after the frame was full.");
endmodule

// ---- rtl/qdac_cmd_core.sv ----
// Command decoder with per-channel data buffers and converter registers.
// Assumes the host keeps every word at least 24 link clocks apart, so the
// held word stays stable while the done toggle crosses to clk_in.
`timescale 1ns/1ps

// Contract
// [RULE1] Capture 24 bits: control 23..16, sample 15..4, bits 3..0 ignored.
// [RULE2] Bits arrive most significant first, starting at bit 23.
// [RULE3] A low frame strobe opens a frame; data sampled on falling clock.
// [RULE4] The 24th falling edge takes the last bit and freezes the word.
// [RULE5] Decode and execute right after the 24th edge, not at strobe rise.
// [RULE6] Strobe rising before 24 bits discards the word, changes nothing.
// [RULE7] After 24 bits a new frame starts only at the next strobe fall.
// [RULE8] The sample is straight binary, zero to full scale minus one.
// [RULE9] Bits 23 and 22 must match the address pins unless broadcast.
// [RULE10] The host always sends bit 19 as zero.
// [RULE11] Bits 18 and 17 select the destination channel.
// [RULE12] Bit 16 marks a power-down command instead of a sample; the code still loads the 12 sample bits beside the flag.
// [RULE13] Load 00 writes only the selected channel's data buffer.
// [RULE14] Load 01 writes buffer and converter register of the channel.
// [RULE15] Load 10 loads the channel; others load registers from buffers.
// [RULE16] Load 11 is a broadcast, accepted whatever the address bits.
// [RULE17] Broadcast with bit 18 clear loads all registers from buffers.
// [RULE18] Broadcast with bit 18 set loads the received value everywhere.
// [RULE19] Selector 00, 01, 10, 11 picks channels A, B, C, D.
// [RULE20] Reset clears every converter register to zero scale.
// [RULE21] Falling link edges are counted; the count clears on strobe high.
module qdac_cmd_core #(
    parameter int CHAN_N = qdac_pkg::CHAN_N
) (
    input  wire logic                                   clk_in,
    input  wire logic                                   rst_in,
    input  wire logic                                   ce_in,
    input  wire logic                                   sclk_in,
    input  wire logic                                   frame_n_in,
    input  wire logic                                   sdata_in,
    input  wire logic                                   address_pin_hi_in,
    input  wire logic                                   address_pin_lo_in,
    output logic [CHAN_N*qdac_pkg::DATA_W-1:0]          dac_value_out,
    output logic [CHAN_N-1:0]                           dac_pd_out,
    output logic                                        cmd_done_out
);
    typedef logic [qdac_pkg::ENTRY_W-1:0] qdac_entry_t;

    typedef struct packed {
        logic [2:0]                    tgl_sync;
        logic [1:0]                    hi_sync;
        logic [1:0]                    lo_sync;
        logic [CHAN_N-1:0][qdac_pkg::ENTRY_W-1:0] buffer;
        logic [CHAN_N-1:0][qdac_pkg::ENTRY_W-1:0] dac;
        logic                          done;
    } qdac_core_t;

    qdac_core_t                   cur_q, cur_d;
    logic [qdac_pkg::WORD_W-1:0]  link_word;
    logic                         link_tgl;
    logic                         new_cmd;
    logic                         adr_ok;
    logic [1:0]                   load_ctrl;
    logic [1:0]                   chan_sel;
    qdac_entry_t                  entry;

    qdac_link_rx u_rx (
        .rst_in       (rst_in),
        .sclk_in      (sclk_in),
        .frame_n_in   (frame_n_in),
        .sdata_in     (sdata_in),
        .word_out     (link_word),
        .word_tgl_out (link_tgl)
    );

    // The power-down flag rides above the 12 sample bits in each entry.
    function automatic qdac_entry_t word_entry(
        input logic [qdac_pkg::WORD_W-1:0] w
    );
        word_entry = {w[qdac_pkg::PD_BIT], // [RULE12]
                      w[qdac_pkg::DATA_HI_BIT:qdac_pkg::DATA_LO_BIT]}; // [RULE8]
    endfunction

    always_comb begin
        cur_d          = cur_q;
        cur_d.done     = 1'b0;
        cur_d.tgl_sync = {cur_q.tgl_sync[1:0], link_tgl};
        cur_d.hi_sync  = {cur_q.hi_sync[0], address_pin_hi_in};
        cur_d.lo_sync  = {cur_q.lo_sync[0], address_pin_lo_in};
        load_ctrl = link_word[qdac_pkg::LOAD_HI_BIT:qdac_pkg::LOAD_LO_BIT];
        chan_sel  = link_word[qdac_pkg::SEL_HI_BIT:qdac_pkg::SEL_LO_BIT];
        entry     = word_entry(link_word);
        // The address synchronisers are read at their second stage; the toggle compares its second and third stages.
        new_cmd   = cur_q.tgl_sync[1] ^ cur_q.tgl_sync[2]; // [RULE5]
        adr_ok    = (link_word[qdac_pkg::ADDR_HI_BIT] == cur_q.hi_sync[1]) &&
                    (link_word[qdac_pkg::ADDR_LO_BIT] == cur_q.lo_sync[1]); // [RULE9]
        if (new_cmd) begin
            if (load_ctrl == qdac_pkg::LOAD_BCAST) begin // [RULE16]
                cur_d.done = 1'b1;
                for (int i = 0; i < CHAN_N; i++) begin
                    if (link_word[qdac_pkg::SEL_HI_BIT]) begin
                        cur_d.buffer[i] = entry; // [RULE18]
                        cur_d.dac[i]    = entry;
                    end else begin
                        cur_d.dac[i] = cur_q.buffer[i]; // [RULE17]
                    end
                end
            end else if (adr_ok) begin // [RULE9]
                cur_d.done = 1'b1;
                cur_d.buffer[chan_sel] = entry; // [RULE11] [RULE19] [RULE13]
                if (load_ctrl == qdac_pkg::LOAD_SINGLE) begin
                    cur_d.dac[chan_sel] = entry; // [RULE14]
                end else if (load_ctrl == qdac_pkg::LOAD_SIMUL) begin
                    for (int i = 0; i < CHAN_N; i++) begin
                        cur_d.dac[i] = (i == int'(chan_sel)) ?
                                       entry : cur_q.buffer[i]; // [RULE15]
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_q <= '0; // [RULE20]
        end else if (ce_in) begin
            cur_q <= cur_d;
        end
    end

    generate
        for (genvar g = 0; g < CHAN_N; g++) begin : g_out
            assign dac_value_out[g*qdac_pkg::DATA_W +: qdac_pkg::DATA_W] =
                cur_q.dac[g][qdac_pkg::DATA_W-1:0];
            assign dac_pd_out[g] = cur_q.dac[g][qdac_pkg::DATA_W];
        end
    endgenerate
    assign cmd_done_out = cur_q.done;

    chk_exec_latency: assert property ( // [RULE5]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && load_ctrl == qdac_pkg::LOAD_BCAST)
        |=> cmd_done_out)
        else $error("Broadcast did not complete one cycle after arrival.");

    chk_addr_miss: assert property ( // [RULE9]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && !adr_ok && load_ctrl != qdac_pkg::LOAD_BCAST)
        |=> ($stable(cur_q.buffer) && $stable(cur_q.dac) && !cmd_done_out))
        else $error("Unaddressed command changed channel state.");

    chk_store_only: assert property ( // [RULE13]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_STORE)
        |=> ($stable(cur_q.dac) && cur_q.buffer[$past(chan_sel)] ==
             $past(entry)))
        else $error("Store command touched a converter register.");

    chk_single_load: assert property ( // [RULE14]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SINGLE)
        |=> (cur_q.dac[$past(chan_sel)] == $past(entry)))
        else $error("Single update missed the converter register.");

    chk_simul_load: assert property ( // [RULE15]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SIMUL &&
         chan_sel != 2'h0)
        |=> (cur_q.dac[0] == $past(cur_q.buffer[0])))
        else $error("Simultaneous update skipped an unselected channel.");

    chk_bcast_buffers: assert property ( // [RULE17]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && load_ctrl == qdac_pkg::LOAD_BCAST &&
         !link_word[qdac_pkg::SEL_HI_BIT])
        |=> (cur_q.dac == $past(cur_q.buffer) && $stable(cur_q.buffer)))
        else $error("Broadcast reload did not copy buffers.");

    chk_bcast_value: assert property ( // [RULE18]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && load_ctrl == qdac_pkg::LOAD_BCAST &&
         link_word[qdac_pkg::SEL_HI_BIT])
        |=> (cur_q.dac[CHAN_N-1] == $past(entry) &&
             cur_q.buffer[0] == $past(entry)))
        else $error("Broadcast value did not reach every channel.");

    chk_chan_map: assert property ( // [RULE19]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SINGLE &&
         chan_sel == 2'h3)
        |=> (dac_value_out[CHAN_N*qdac_pkg::DATA_W-1 -: qdac_pkg::DATA_W] ==
             $past(link_word[qdac_pkg::DATA_HI_BIT:qdac_pkg::DATA_LO_BIT])))
        else $error("Selector 11 did not address the last channel.");

    chk_freeze_ce: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !ce_in |=> $stable(cur_q))
        else $error("State moved while the clock enable was low.");

    // Each command check looks one cycle after the decode that it guards.
    chk_done_pulse: assert property ( // [RULE5]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && cmd_done_out) |=> !cmd_done_out)
        else $error("Done pulse lasted more than one cycle.");

    chk_no_spurious: assert property ( // [RULE6]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && !new_cmd) |=> !cmd_done_out)
        else $error("Done pulse without a complete word.");

    chk_idle_hold: assert property ( // [RULE6]
        @(posedge clk_in) disable iff (rst_in)
        !new_cmd |=> ($stable(cur_q.buffer) && $stable(cur_q.dac)))
        else $error("Channel state changed without a command.");

    chk_reset_zero: assert property ( // [RULE20]
        @(posedge clk_in)
        $fell(rst_in) |-> (dac_value_out == '0 && dac_pd_out == '0 &&
                           !cmd_done_out))
        else $error("Outputs not at zero scale after reset.");

    chk_addr_hit: assert property ( // [RULE9]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok) |=> cmd_done_out)
        else $error("Addressed command did not execute.");

    chk_bcast_any_addr: assert property ( // [RULE16]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && !adr_ok && load_ctrl == qdac_pkg::LOAD_BCAST)
        |=> cmd_done_out)
        else $error("Broadcast was refused on an address mismatch.");

    chk_sel_decode: assert property ( // [RULE11]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_STORE &&
         chan_sel == 2'h2)
        |=> (cur_q.buffer[2] == $past(entry)))
        else $error("Selector 10 did not address the third channel.");

    chk_pd_single: assert property ( // [RULE12]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SINGLE)
        |=> (dac_pd_out[$past(chan_sel)] ==
             $past(link_word[qdac_pkg::PD_BIT])))
        else $error("Power-down flag did not reach the channel.");

    chk_pd_store: assert property ( // [RULE12]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_STORE)
        |=> (cur_q.buffer[$past(chan_sel)][qdac_pkg::DATA_W] ==
             $past(link_word[qdac_pkg::PD_BIT])))
        else $error("Power-down flag did not reach the buffer.");

    chk_data_single: assert property ( // [RULE8]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SINGLE)
        |=> (cur_q.dac[$past(chan_sel)][qdac_pkg::DATA_W-1:0] ==
             $past(link_word[qdac_pkg::DATA_HI_BIT:qdac_pkg::DATA_LO_BIT])))
        else $error("Sample code was altered on its way to the register.");

    chk_store_others: assert property ( // [RULE13]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_STORE &&
         chan_sel != 2'h0)
        |=> (cur_q.buffer[0] == $past(cur_q.buffer[0])))
        else $error("Store command touched an unselected buffer.");

    chk_single_buffer: assert property ( // [RULE14]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SINGLE)
        |=> (cur_q.buffer[$past(chan_sel)] == $past(entry)))
        else $error("Single update missed the data buffer.");

    chk_single_others: assert property ( // [RULE14]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SINGLE &&
         chan_sel != 2'h0)
        |=> (cur_q.dac[0] == $past(cur_q.dac[0])))
        else $error("Single update touched an unselected register.");

    chk_simul_select: assert property ( // [RULE15]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SIMUL)
        |=> (cur_q.dac[$past(chan_sel)] == $past(entry) &&
             cur_q.buffer[$past(chan_sel)] == $past(entry)))
        else $error("Simultaneous update missed the selected channel.");

    chk_simul_last: assert property ( // [RULE15]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SIMUL &&
         chan_sel != 2'h3)
        |=> (cur_q.dac[CHAN_N-1] == $past(cur_q.buffer[CHAN_N-1])))
        else $error("Simultaneous update skipped the last channel.");

    chk_bcast_all: assert property ( // [RULE18]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && load_ctrl == qdac_pkg::LOAD_BCAST &&
         link_word[qdac_pkg::SEL_HI_BIT])
        |=> (cur_q.dac == {CHAN_N{$past(entry)}} &&
             cur_q.buffer == {CHAN_N{$past(entry)}}))
        else $error("Broadcast value missed a channel.");

    chk_map_first: assert property ( // [RULE19]
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && new_cmd && adr_ok && load_ctrl == qdac_pkg::LOAD_SINGLE &&
         chan_sel == 2'h0)
        |=> (dac_value_out[qdac_pkg::DATA_W-1:0] ==
             $past(link_word[qdac_pkg::DATA_HI_BIT:qdac_pkg::DATA_LO_BIT])))
        else $error("Selector 00 did not address the first channel.");
endmodule

// ---- verification/qdac_host_model.sv ----
// Serial master that sends one frame of up to 31 falling link edges.
// Assumes start_in rises only while busy_out is low.
`timescale 1ns/1ps
module qdac_host_model (
    input  wire logic        start_in,
    input  wire logic [23:0] word_in,
    input  wire logic [4:0]  nbits_in,
    output logic             sclk_out,
    output logic             frame_n_out,
    output logic             sdata_out,
    output logic             busy_out
);
    initial begin
        sclk_out    = 1'b0;
        frame_n_out = 1'b1;
        sdata_out   = 1'b0;
        busy_out    = 1'b0;
    end
    // The link clock moves only inside a frame, at a 64 ns period.
    always @(posedge start_in) begin
        busy_out = 1'b1;
        #7 frame_n_out = 1'b0;
        for (int i = 0; i < nbits_in; i++) begin
            sdata_out = (i < 24) ? word_in[23-i] : ~sdata_out;
            #16 sclk_out = 1'b1;
            #32 sclk_out = 1'b0;
            #16;
        end
        // Data is released after the last bit, while the strobe is still low,
        // so it toggles away from the last bit instead of holding it.
        sdata_out = ~sdata_out;
        #400 frame_n_out = 1'b1;
        #100 busy_out = 1'b0;
    end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the quad converter command front end.
// Assumes qdac_cmd_core and qdac_host_model are compiled before it.
`timescale 1ns/1ps
module tb;
    logic        clk_in, rst_in, start, sclk, frame_n, sdata, busy, done, ce;
    logic [23:0] word;
    logic [4:0]  nbits;
    logic [1:0]  addr;
    logic [47:0] value;
    logic [3:0]  pd;
    logic [12:0] bf [4];
    logic [12:0] dc [4];
    int          n_fail, n_compared, exp_done, n_done, n_late;

    qdac_cmd_core qdac_cmd_core_i (.clk_in(clk_in), .rst_in(rst_in),
        .ce_in(ce), .sclk_in(sclk), .frame_n_in(frame_n),
        .sdata_in(sdata), .address_pin_hi_in(addr[1]),
        .address_pin_lo_in(addr[0]), .dac_value_out(value),
        .dac_pd_out(pd), .cmd_done_out(done));
    qdac_host_model qdac_host_model_i (.start_in(start), .word_in(word),
        .nbits_in(nbits), .sclk_out(sclk), .frame_n_out(frame_n),
        .sdata_out(sdata), .busy_out(busy));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Every executed command is counted; one seen after strobe rise is late.
    always @(posedge clk_in) begin
        if (done === 1'b1) begin
            n_done++;
            if (frame_n !== 1'b0) n_late++;
        end
    end

    task test_done;
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (e !== g) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task wait_busy(input logic lvl);
        for (int k = 0; k < 400 && busy !== lvl; k++) @(posedge clk_in);
        if (busy !== lvl) begin
            cmp("host_busy", lvl, busy);
            test_done();
        end
    endtask
    task check_out;
        logic [47:0] v;
        logic [3:0]  p;
        for (int i = 0; i < 4; i++) begin
            v[i*12 +: 12] = dc[i][11:0];
            p[i] = dc[i][12];
        end
        cmp("dac_value", v, value);
        cmp("dac_pd", p, pd);
        cmp("done_count", exp_done, n_done);
        cmp("late_done", 0, n_late);
    endtask
    function automatic logic [23:0] mk(logic [1:0] a, logic [1:0] ld,
        logic [1:0] sel, logic pdn, logic [11:0] d);
        return {a, ld, 1'b0, sel, pdn, d, 4'hA};
    endfunction
    task send(input logic [23:0] w, input logic [4:0] nb);
        logic [12:0] e;
        logic [1:0]  s;
        e = {w[16], w[15:4]};
        s = w[18:17];
        @(posedge clk_in);
        word  <= w;
        nbits <= nb;
        start <= 1'b1;
        wait_busy(1'b1);
        start <= 1'b0;
        wait_busy(1'b0);
        if (nb >= 5'h18 && (w[21:20] == 2'h3 || w[23:22] == addr)) begin
            exp_done++;
            case (w[21:20])
                2'h0: bf[s] = e;
                2'h1: begin bf[s] = e; dc[s] = e; end
                2'h2: begin
                    bf[s] = e;
                    for (int i = 0; i < 4; i++) dc[i] = bf[i];
                end
                default: for (int i = 0; i < 4; i++) begin
                    if (w[18]) bf[i] = e;
                    dc[i] = bf[i];
                end
            endcase
        end
        check_out();
    endtask

    task t_store;
        for (int c = 0; c < 4; c++)
            send(mk(addr, 2'h0, c[1:0], 1'b0, 12'h123 * (c + 1)), 5'h18);
    endtask
    task t_single;
        send(mk(addr, 2'h1, 2'h1, 1'b0, 12'hFFF), 5'h18);
        send(mk(addr, 2'h1, 2'h3, 1'b0, 12'h000), 5'h18);
    endtask
    task t_simul;
        send(mk(addr, 2'h2, 2'h2, 1'b0, 12'h5A5), 5'h18);
    endtask
    task t_bcast;
        send(mk(addr, 2'h0, 2'h0, 1'b0, 12'h321), 5'h18);
        send(mk(~addr, 2'h3, 2'h0, 1'b0, 12'hABC), 5'h18);
        send(mk(~addr, 2'h3, 2'h2, 1'b1, 12'h800), 5'h18);
    endtask
    task t_reject;
        send(mk(~addr, 2'h1, 2'h0, 1'b0, 12'h777), 5'h18);
        send(mk(addr, 2'h1, 2'h0, 1'b0, 12'h666), 5'h17);
    endtask
    task t_extra;
        send(mk(addr, 2'h1, 2'h0, 1'b0, 12'h3C3), 5'h1F);
        send(mk(addr, 2'h1, 2'h3, 1'b0, 12'h0F0), 5'h18);
    endtask
    // The enable is held low past the last bit; the command must wait
    // for it, then execute while the strobe is still low.
    task t_freeze;
        @(posedge clk_in);
        ce <= 1'b0;
        fork
            send(mk(addr, 2'h2, 2'h2, 1'b0, 12'h9C9), 5'h18);
            begin
                repeat (180) @(posedge clk_in);
                check_out();
                ce <= 1'b1;
            end
        join
    endtask

    initial begin
        rst_in = 1'b1;
        start = 1'b0;
        ce = 1'b1;
        word = 24'h000000;
        nbits = 5'h00;
        addr = 2'h2;
        n_fail = 0;
        n_compared = 0;
        exp_done = 0;
        n_done = 0;
        n_late = 0;
        for (int i = 0; i < 4; i++) begin
            bf[i] = 13'h0000;
            dc[i] = 13'h0000;
        end
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        check_out();
        t_store();
        t_single();
        t_simul();
        t_bcast();
        t_reject();
        t_extra();
        t_freeze();
        test_done();
    end
endmodule
